// ---- design/hv_wake_consts.vh ----
/*
 Timing counts, field codes and mode codes for the wake input monitor.
 Assumes a 250 MHz system clock; included by the wake monitor module only.
*/
// Overview of operation
// - Both edges of each pin are wake events
// - Interrupt in Normal/Stop, wake in Sleep/Fail-Safe
// - Static senses always, cyclic only in window
// - Accept wake only if stable through filter
// - Detect field selects static/cyclic and filter
// - Pull field: none, down, up, automatic
// - Automatic: pull follows detected pin level
// - Per-pin wake enable bit gates wake
// - Wake sets own source flag, readable always
// - Level status shows level or sampled level
// - Fail outputs as wakes: fixed short filter
// - Measurement off after reset, switch open
// - Switch closes only in Normal when enabled
// - Measurement gates pins 1,2 and pulls
// - Pin 1,2 settings kept but ignored
// - No status updates for pins 1,2
// - Sleep with only pins 1,2 fails, restarts
// - Short filter between 12 and 20 us
`ifndef HV_WAKE_CONSTS_VH
`define HV_WAKE_CONSTS_VH
`define CLK_MHZ 250
`define FILT_SHORT_US 16
`define FILT_LONG_US 64
`define FILT_SHORT_CYC (`FILT_SHORT_US * `CLK_MHZ)
`define FILT_LONG_CYC (`FILT_LONG_US * `CLK_MHZ)
`define DET_STATIC_SHORT 2'h0
`define DET_STATIC_LONG 2'h1
`define DET_CYCLIC_T1 2'h2
`define DET_CYCLIC_T2 2'h3
`define PULL_NONE 2'h0
`define PULL_DOWN 2'h1
`define PULL_UP 2'h2
`define PULL_AUTO 2'h3
`define MODE_NORMAL 3'h0
`define MODE_STOP 3'h1
`define MODE_SLEEP 3'h2
`define MODE_FAILSAFE 3'h3
`define FILTER_CNT_W 15
`endif

// ---- design/hv_wake_input_monitor.v ----
/*
 Wake input monitor for three high-voltage wake pins and two fail outputs used as wakes.
 Assumes comparator outputs arrive asynchronously, timer windows and mode come from the same clock.
*/
`timescale 1ns/1ns
`include "hv_wake_consts.vh"
module hv_wake_input_monitor #(
	parameter FILT_SHORT = `FILT_SHORT_CYC,
	parameter FILT_LONG = `FILT_LONG_CYC
) (
	input wire i_sys_clk,
	input wire i_reset,
	input wire [2:0] i_wake_pin,
	input wire [1:0] i_fail_output_wake,
	input wire [1:0] i_fail_output_wake_enable,
	input wire [2:0] i_wake_enable_control,
	input wire [5:0] i_detect_filter_control,
	input wire [5:0] i_pull_current_control,
	input wire i_measure_enable,
	input wire [2:0] i_mode,
	input wire i_timer_one_window,
	input wire i_timer_two_window,
	input wire i_sleep_command,
	input wire i_clear_status_a,
	input wire i_clear_status_b,
	output reg [2:0] o_wake_source_status_a,
	output reg [1:0] o_wake_source_status_b,
	output reg [2:0] o_pin_level_status,
	output reg [2:0] o_pull_up_on,
	output reg [2:0] o_pull_down_on,
	output reg o_measurement_switch,
	output reg o_wake_interrupt,
	output reg o_wake_up,
	output reg o_spi_fail,
	output reg o_restart
);
// ==========================================
// Local sizes and filter limits
localparam NUM_IN = 5;
localparam NUM_PIN = 3;
localparam [`FILTER_CNT_W-1:0] LIM_SHORT = FILT_SHORT[`FILTER_CNT_W-1:0];
localparam [`FILTER_CNT_W-1:0] LIM_LONG = FILT_LONG[`FILTER_CNT_W-1:0];

// ==========================================
// Input synchronisers and filter state
reg [4:0] sync1;
reg [4:0] sync2;
reg [4:0] sync3;
reg [4:0] stable;
reg [4:0] accepted;
reg [4:0] pending;
reg [4:0] wake_evt;
reg [`FILTER_CNT_W-1:0] cnt [0:4];
integer k;
integer j;
integer m;

wire [4:0] raw_in = {i_fail_output_wake, i_wake_pin};
wire meas = i_measure_enable;

// Measurement takes pins one and two away from wake processing
wire [4:0] gated = {3'h0, meas, meas};

// Second and third stage agree: the level counts
wire [4:0] agree = ~(sync2 ^ sync3);
wire [4:0] crossing = agree & (sync3 ^ stable) & ~gated;

// ==========================================
// Field decoding
function [1:0] det_of;
	input integer p;
	begin
		if (p < NUM_PIN) begin
			det_of = i_detect_filter_control[2*p +: 2];
		end else begin
			det_of = `DET_STATIC_SHORT;
		end
	end
endfunction

function [`FILTER_CNT_W-1:0] filt_limit;
	input [1:0] dsel;
	begin
		if (dsel == `DET_STATIC_LONG) begin
			filt_limit = LIM_LONG;
		end else begin
			filt_limit = LIM_SHORT;
		end
	end
endfunction

function active_window;
	input [1:0] dsel;
	begin
		case (dsel)
			`DET_CYCLIC_T1: begin
				active_window = i_timer_one_window;
			end
			`DET_CYCLIC_T2: begin
				active_window = i_timer_two_window;
			end
			default: begin
				active_window = 1'b1;
			end
		endcase
	end
endfunction

function [1:0] pull_of;
	input integer p;
	begin
		pull_of = i_pull_current_control[2*p +: 2];
	end
endfunction

// ==========================================
// Three-stage synchroniser
always @(posedge i_sys_clk or posedge i_reset) begin
	if (i_reset) begin
		sync1 <= 5'h00;
		sync2 <= 5'h00;
		sync3 <= 5'h00;
	end else begin
		sync1 <= raw_in;
		sync2 <= sync1;
		sync3 <= sync2;
	end
end

// ==========================================
// Glitch filters, one counter per input
always @(posedge i_sys_clk or posedge i_reset) begin
	if (i_reset) begin
		stable <= 5'h00;
		accepted <= 5'h00;
		pending <= 5'h00;
		wake_evt <= 5'h00;
		for (k = 0; k < NUM_IN; k = k + 1) begin
			cnt[k] <= {`FILTER_CNT_W{1'b0}};
		end
	end else begin
		for (k = 0; k < NUM_IN; k = k + 1) begin
			wake_evt[k] <= 1'b0;
			if (gated[k]) begin
				pending[k] <= 1'b0;
				cnt[k] <= {`FILTER_CNT_W{1'b0}};
			end else if (crossing[k]) begin
				stable[k] <= sync3[k];
				pending[k] <= active_window(det_of(k));
				cnt[k] <= {`FILTER_CNT_W{1'b0}};
			end else if (pending[k] && agree[k]) begin
				if (cnt[k] >= filt_limit(det_of(k)) - 1'b1) begin
					pending[k] <= 1'b0;
					accepted[k] <= stable[k];
					// A glitch that returns to the accepted level is no wake
					wake_evt[k] <= (stable[k] != accepted[k]);
				end else begin
					cnt[k] <= cnt[k] + 1'b1;
				end
			end
		end
	end
end

// ==========================================
// Wake qualification and mode decoding
wire [2:0] pin_en = i_wake_enable_control & {1'b1, ~meas, ~meas};
wire [2:0] pin_wake = wake_evt[2:0] & pin_en;
wire [1:0] fo_wake = wake_evt[4:3] & i_fail_output_wake_enable;
wire any_wake = (|pin_wake) | (|fo_wake);
wire low_power = (i_mode == `MODE_SLEEP) || (i_mode == `MODE_FAILSAFE);
wire run_mode = (i_mode == `MODE_NORMAL) || (i_mode == `MODE_STOP);

// Pins one and two are the only wake sources left
wire only_pins_12 = (|i_wake_enable_control[1:0]) && !i_wake_enable_control[2]
	&& !(|i_fail_output_wake_enable);
wire sleep_fault = i_sleep_command && meas && only_pins_12;

// ==========================================
// Wake source status, first set
always @(posedge i_sys_clk or posedge i_reset) begin
	if (i_reset) begin
		o_wake_source_status_a <= 3'h0;
	end else begin
		// A new wake wins over a clear in the same cycle
		o_wake_source_status_a <= (o_wake_source_status_a & ~{3{i_clear_status_a}}) | pin_wake;
	end
end

// ==========================================
// Wake source status, second set
always @(posedge i_sys_clk or posedge i_reset) begin
	if (i_reset) begin
		o_wake_source_status_b <= 2'h0;
	end else begin
		o_wake_source_status_b <= (o_wake_source_status_b & ~{2{i_clear_status_b}}) | fo_wake;
	end
end

// ==========================================
// Pin level status
always @(posedge i_sys_clk or posedge i_reset) begin
	if (i_reset) begin
		o_pin_level_status <= 3'h0;
	end else begin
		for (j = 0; j < NUM_PIN; j = j + 1) begin
			if (run_mode && !gated[j]) begin
				o_pin_level_status[j] <= stable[j];
			end
		end
	end
end

// ==========================================
// Pull current sources
always @(posedge i_sys_clk or posedge i_reset) begin
	if (i_reset) begin
		o_pull_up_on <= 3'h0;
		o_pull_down_on <= 3'h0;
	end else begin
		for (m = 0; m < NUM_PIN; m = m + 1) begin
			if (gated[m]) begin
				o_pull_up_on[m] <= 1'b0;
				o_pull_down_on[m] <= 1'b0;
			end else begin
				case (pull_of(m))
					`PULL_DOWN: begin
						o_pull_up_on[m] <= 1'b0;
						o_pull_down_on[m] <= 1'b1;
					end
					`PULL_UP: begin
						o_pull_up_on[m] <= 1'b1;
						o_pull_down_on[m] <= 1'b0;
					end
					`PULL_AUTO: begin
						o_pull_up_on[m] <= stable[m];
						o_pull_down_on[m] <= ~stable[m];
					end
					default: begin
						o_pull_up_on[m] <= 1'b0;
						o_pull_down_on[m] <= 1'b0;
					end
				endcase
			end
		end
	end
end

// ==========================================
// Measurement switch
always @(posedge i_sys_clk or posedge i_reset) begin
	if (i_reset) begin
		o_measurement_switch <= 1'b0;
	end else begin
		o_measurement_switch <= meas && (i_mode == `MODE_NORMAL);
	end
end

// ==========================================
// Interrupt and wake pulses
always @(posedge i_sys_clk or posedge i_reset) begin
	if (i_reset) begin
		o_wake_interrupt <= 1'b0;
		o_wake_up <= 1'b0;
	end else begin
		o_wake_interrupt <= any_wake && run_mode;
		o_wake_up <= any_wake && low_power;
	end
end

// ==========================================
// Sleep refused while only measured pins could wake
always @(posedge i_sys_clk or posedge i_reset) begin
	if (i_reset) begin
		o_spi_fail <= 1'b0;
		o_restart <= 1'b0;
	end else begin
		o_spi_fail <= sleep_fault;
		o_restart <= sleep_fault;
	end
end

endmodule

// ---- bench/hv_wake_checker_assertions.sv ----
/* Port checker for the wake monitor.
 Bound to the monitor top; sees its ports only. */
`timescale 1ns/1ns
// ==========
// Checker
module hv_wake_checker (
	input wire i_sys_clk,
	input wire i_reset,
	input wire i_measure_enable,
	input wire i_sleep_command,
	input wire [2:0] i_mode,
	input wire [2:0] o_pull_up_on,
	input wire [2:0] o_pull_down_on,
	input wire o_measurement_switch,
	input wire o_wake_interrupt,
	input wire o_wake_up,
	input wire o_spi_fail,
	input wire o_restart
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	sequence meas_on; i_measure_enable [*2]; endsequence
	sequence normal_on; (i_mode == 3'h0) [*2]; endsequence
	AST_SW_OFF: assert property ((!i_measure_enable) [*2] |=> !o_measurement_switch) else $error("switch");
	AST_SW_ON: assert property (meas_on and normal_on |=> o_measurement_switch) else $error("switch");
	AST_SW_MODE: assert property ((i_mode != 3'h0) [*2] |=> !o_measurement_switch) else $error("switch");
	AST_PULL_MEAS: assert property (meas_on |=> (o_pull_up_on[1:0] | o_pull_down_on[1:0]) == 2'h0) else $error("pull");
	AST_PULL_EXCL: assert property ((o_pull_up_on & o_pull_down_on) == 3'h0) else $error("pull");
	AST_INT_MODE: assert property ((i_mode > 3'h1) [*2] |=> !o_wake_interrupt) else $error("int");
	AST_WAKE_MODE: assert property ((i_mode < 3'h2) [*2] |=> !o_wake_up) else $error("wake");
	AST_FAIL: assert property (o_spi_fail |-> $past(i_sleep_command) && $past(i_measure_enable)) else $error("fail");
	AST_RESTART: assert property (o_restart == o_spi_fail) else $error("restart");
endmodule
bind hv_wake_input_monitor hv_wake_checker u_chk (.*);

// ---- bench/wake_pin_model.sv ----
/* Switches on the three wake pins.
 Drives or releases each pin; pulls set a released pin. */
`timescale 1ns/1ns
// ==========
// Pin model
module wake_pin_model (
	input wire i_sys_clk,
	input wire [2:0] i_drive,
	input wire [2:0] i_level,
	input wire [2:0] i_pull_up,
	input wire [2:0] i_pull_down,
	output reg [2:0] o_pin
);
	initial o_pin = 3'h0;
	// Unpulled released pin flips each cycle
	always @(posedge i_sys_clk) o_pin <= (i_drive & i_level) | (~i_drive & (i_pull_up | ~i_pull_down & ~o_pin));
endmodule

// ---- bench/hv_wake_input_monitor_tb_top.sv ----
/* Bench for the wake monitor.
 Uses the pin model; the checker is bound. */
`timescale 1ns/1ns
// ==========
// Bench
module hv_wake_input_monitor_tb_top;
	reg i_sys_clk = 0, i_reset = 1, meas = 0, slp = 0, clr = 0, w1 = 0, w2 = 1;
	reg [2:0] lv = 3'h0, drv = 3'h7, en = 3'h7, mode = 3'h0;
	reg [1:0] fo = 2'h0, fe = 2'h3, c;
	reg [5:0] det = 6'h00, pull = 6'h00;
	reg [31:0] sd = 32'h893A7A61;
	wire [2:0] pin, sa, lvl, pu, pd;
	wire [1:0] sb;
	wire sw, wi, wu, sf, rs;
	integer bad_count = 0, comparisons = 0, ni = 0, nw = 0, nf = 0, nr = 0, bi = 0, bw = 0, k, e;
	always #2 i_sys_clk = ~i_sys_clk;
	always @(posedge i_sys_clk) begin
		ni <= ni + wi;
		nw <= nw + wu;
		nf <= nf + sf;
		nr <= nr + rs;
	end
	wake_pin_model u_pins (.i_sys_clk(i_sys_clk), .i_drive(drv), .i_level(lv), .i_pull_up(pu), .i_pull_down(pd), .o_pin(pin));
	hv_wake_input_monitor #(.FILT_SHORT(8), .FILT_LONG(32)) u_dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset),
		.i_wake_pin(pin), .i_fail_output_wake(fo), .i_fail_output_wake_enable(fe), .i_wake_enable_control(en),
		.i_detect_filter_control(det), .i_pull_current_control(pull), .i_measure_enable(meas), .i_mode(mode),
		.i_timer_one_window(w1), .i_timer_two_window(w2), .i_sleep_command(slp), .i_clear_status_a(clr),
		.i_clear_status_b(clr), .o_wake_source_status_a(sa), .o_wake_source_status_b(sb), .o_pin_level_status(lvl),
		.o_pull_up_on(pu), .o_pull_down_on(pd), .o_measurement_switch(sw), .o_wake_interrupt(wi), .o_wake_up(wu),
		.o_spi_fail(sf), .o_restart(rs));
	function [31:0] xs(input [31:0] x);
		xs = x ^ (x << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction
	task chk(input [31:0] n, input [31:0] x, input [31:0] y);
		comparisons = comparisons + 1;
		if (x !== y) begin
			bad_count = bad_count + 1;
			$display("Error %s expected %0h seen %0h", n, x, y);
		end
	endtask
	task tst(input [2:0] p, input integer h, input [2:0] ea, input integer ei, input integer ew);
		bi = ni;
		bw = nw;
		lv = lv ^ p;
		if (h > 0) begin
			repeat (h) @(negedge i_sys_clk);
			lv = lv ^ p;
		end
		repeat (60) @(negedge i_sys_clk);
		chk("sta", ea, sa);
		chk("int", ei, ni - bi);
		chk("wake", ew, nw - bw);
		clr = 1;
		@(negedge i_sys_clk) clr = 0;
		$display("test end");
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#20000;
		bad_count = bad_count + 1;
		tally_and_finish;
	end
	initial begin
		repeat (11) @(negedge i_sys_clk);
		i_reset = 0;
		chk("rst", 0, {sa, sb, sw});
		for (k = 0; k < 6; k = k + 1) begin
			det = k < 3 ? 6'h00 : 6'h15;
			tst(3'h1 << k % 3, 0, 3'h1 << k % 3, 1, 0);
			if (k == 2) begin
				chk("lvl", lv, lvl);
			end
		end
		tst(3'h1, 20, 3'h0, 0, 0);
		det = 6'h3F;
		tst(3'h4, 0, 3'h4, 1, 0);
		det = 6'h2A;
		tst(3'h4, 0, 3'h0, 0, 0);
		det = 6'h00;
		en = 3'h6;
		tst(3'h1, 0, 3'h0, 0, 0);
		en = 3'h7;
		mode = 3'h2;
		tst(3'h1, 0, 3'h1, 0, 1);
		mode = 3'h0;
		fo = 2'h1;
		repeat (60) @(negedge i_sys_clk);
		chk("stb", 1, sb);
		meas = 1;
		tst(3'h3, 0, 3'h0, 0, 0);
		chk("sw", 1, sw);
		chk("lvl", lv ^ 3'h3, lvl);
		en = 3'h3;
		fe = 2'h0;
		slp = 1;
		@(negedge i_sys_clk) slp = 0;
		repeat (4) @(negedge i_sys_clk);
		chk("fail", 1, nf);
		chk("rest", 1, nr);
		meas = 0;
		en = 3'h7;
		drv = 3'h3;
		e = lv[2];
		for (k = 0; k < 8; k = k + 1) begin
			sd = xs(sd);
			c = sd[1:0] ? sd[1:0] : 2'h1;
			pull = {c, 4'h0};
			if (c != 2'h3) e = c[1];
			repeat (60) @(negedge i_sys_clk);
			chk("lvl2", e, lvl[2]);
			chk("pull", c == 2'h3 ? {e[0], !e[0]} : c, {pu[2], pd[2]});
		end
		tally_and_finish;
	end
endmodule
